/* File: design/wlirp_acc_if.sv */
/*
  wlirp_acc_if: register access strobes from the page decoder to a unit.
  assumes: one clock; strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
interface wlirp_acc_if;
  logic        sel;
  logic        wr;
  logic        rd;
  logic [2:0]  idx;
  logic [15:0] wdata;

  modport ctrl (output sel, output wr, output rd, output idx, output wdata);
  modport unit (input sel, input wr, input rd, input idx, input wdata);
endinterface : wlirp_acc_if

/* File: design/wlirp_event_unit.sv */
/*
  wlirp_event_unit: sticky event mask and read-clearing event status.
  assumes: event inputs are one-cycle pulses or levels on the clock.
*/
`timescale 1ns/1ps
module wlirp_event_unit
  import wlirp_pkg::*;
#(
  parameter logic [15:0] BITS = EVT_BITS
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        soft_reset_i,
  wlirp_acc_if.unit        acc,
  input  wire logic [15:0] event_i,
  output logic [15:0]      rdata_o,
  output logic [15:0]      status_o,
  output logic [15:0]      mask_o,
  output logic             irq_o
);

  if (BITS == 16'h0000) begin : g_chk
    $error("wlirp_event_unit: no event bits");
  end

  logic wr_mask;
  logic rd_status;

  assign wr_mask   = acc.sel && acc.wr && acc.idx == 3'h0;
  assign rd_status = acc.sel && acc.rd && acc.idx == 3'h1;

  //////////////////////////////////////////////////////////////////////////
  for (genvar b = 0; b < 16; b++) begin : g_bit
    if (BITS[b]) begin : g_live
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          mask_o[b] <= EVT_RESET[b];
        end else if (wr_mask) begin
          mask_o[b] <= acc.wdata[b]; // RULE7 RULE13
        end
      end
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          status_o[b] <= EVT_RESET[b];
        end else if (event_i[b]) begin
          status_o[b] <= 1'b1; // RULE8 RULE9
        end else if (rd_status || soft_reset_i) begin
          status_o[b] <= 1'b0; // RULE12
        end
      end
    end else begin : g_rsvd
      assign mask_o[b]   = 1'b0;
      assign status_o[b] = 1'b0;
    end
  end

  assign irq_o = |(status_o & mask_o); // RULE12

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= EVT_RESET;
    end else if (acc.sel && acc.rd) begin
      rdata_o <= (acc.idx == 3'h0) ? mask_o : status_o;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  property p_evt_set;
    @(posedge clk_i) disable iff (reset_i)
    (event_i & BITS) != 16'h0000 |=> (status_o & $past(event_i & BITS))
                                     == $past(event_i & BITS);
  endproperty
  a_evt_set: assert property (p_evt_set) // RULE9
    else $error("event did not set its status bit");

  property p_rd_clear;
    @(posedge clk_i) disable iff (reset_i)
    rd_status && event_i == 16'h0000 |=> status_o == 16'h0000;
  endproperty
  a_rd_clear: assert property (p_rd_clear) // RULE8
    else $error("status not cleared by read");

  property p_mask_wr;
    @(posedge clk_i) disable iff (reset_i)
    wr_mask |=> mask_o == ($past(acc.wdata) & BITS);
  endproperty
  a_mask_wr: assert property (p_mask_wr) // RULE7
    else $error("mask write lost");

  property p_irq;
    @(posedge clk_i) disable iff (reset_i)
    (event_i & mask_o) != 16'h0000 && !wr_mask |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) // RULE12
    else $error("interrupt missing for enabled pending event");

  c_rd_clear: cover property (@(posedge clk_i) disable iff (reset_i)
    status_o != 16'h0000 ##1 rd_status ##1 status_o == 16'h0000);

endmodule : wlirp_event_unit

/* File: design/wlirp_page.sv */
/*
  wlirp_page: wake-on-lan and extended event register page with the
  page select register; reached by indexed register reads and writes.
  assumes: one 200 MHz clock; wr/rd strobes are one-cycle pulses with a
  stable index and data; event inputs synchronous to the clock.
*/
`timescale 1ns/1ps
// Functional notes
// RULE1: wake target address words mid and upper, read/write, zero reset.
// RULE2: password held in three sticky words, zero after reset.
// RULE3: control bit 15 enables password check; bit 14 picks 4 bytes.
// RULE4: field 11:8 gives address repeats minus one, reset 1111.
// RULE5: field 7:5 sets interface edge rate, reset 111 fastest.
// RULE6: control bit 4 gates reference clock output, reset enabled.
// RULE7: mask bits 13, 12, 3..0 enable events, zero reset.
// RULE8: status bits flag pending events at mask positions, self clearing.
// RULE9: status bits 3..0 flag the four energy-efficient events.
// RULE10: controller writes 0x0010 to register 31 for general space.
// RULE11: controller writes 0x0000 to register 31 for main page.
// RULE12: status read clears bits; interrupt while status and mask set.
// RULE13: sticky bits survive soft reset, clear only on hardware reset.
module wlirp_page
  import wlirp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        soft_reset_i,
  input  wire logic [4:0]  mgmt_addr_i,
  input  wire logic [15:0] mgmt_wdata_i,
  input  wire logic        mgmt_wr_i,
  input  wire logic        mgmt_rd_i,
  output logic [15:0]      mgmt_rdata_o,
  output logic [15:0]      reg_page_o,
  input  wire logic        rx_fifo_err_i,
  input  wire logic        tx_fifo_err_i,
  input  wire logic [3:0]  eee_event_i,
  output logic [31:0]      wake_mac_addr_o,
  output logic [47:0]      wake_password_o,
  output logic             secure_on_enable_o,
  output logic             password_four_byte_o,
  output logic [4:0]       addr_repeat_total_o,
  output logic [2:0]       mac_if_edge_rate_o,
  output logic             reduced_mii_reference_clock_out_en_o,
  output logic             event_irq_o,
  output logic             management_interrupt_pin_n_o,
  output logic             management_interrupt_pin_oe_n_o
);

  wlirp_acc_if store_acc ();
  wlirp_acc_if evt_acc ();

  logic [15:0]  page_reg;
  logic [15:0]  ctl_reg;
  logic [15:0]  local_rdata_reg;
  wlirp_rsel_t  rsel_reg;
  wlirp_rsel_t  rsel_next;
  logic         ext_page;
  logic         hit_page;
  logic         hit_store;
  logic         hit_ctl;
  logic         hit_evt;
  logic [15:0]  store_rdata;
  logic [79:0]  store_words;
  logic [15:0]  evt_rdata;
  logic [15:0]  evt_status;
  logic [15:0]  evt_mask;
  logic [15:0]  evt_vec;
  logic         irq;
  logic         int_n_reg;
  logic         int_oe_n_reg;

  //////////////////////////////////////////////////////////////////////////
  // address decode
  assign ext_page  = (page_reg == PAGE_EXT2);
  assign hit_page  = (mgmt_addr_i == IDX_PAGE);
  assign hit_store = ext_page && mgmt_addr_i >= IDX_MAC_MID
                     && mgmt_addr_i <= IDX_PW_UPPER;
  assign hit_ctl   = ext_page && mgmt_addr_i == IDX_CTL;
  assign hit_evt   = ext_page && (mgmt_addr_i == IDX_EVT_MASK
                     || mgmt_addr_i == IDX_EVT_STATUS);

  assign store_acc.sel   = hit_store;
  assign store_acc.wr    = mgmt_wr_i;
  assign store_acc.rd    = mgmt_rd_i;
  assign store_acc.idx   = 3'(mgmt_addr_i - IDX_MAC_MID);
  assign store_acc.wdata = mgmt_wdata_i;

  assign evt_acc.sel     = hit_evt;
  assign evt_acc.wr      = mgmt_wr_i;
  assign evt_acc.rd      = mgmt_rd_i;
  assign evt_acc.idx     = 3'(mgmt_addr_i - IDX_EVT_MASK);
  assign evt_acc.wdata   = mgmt_wdata_i;

  //////////////////////////////////////////////////////////////////////////
  // page select register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      page_reg <= PAGE_RESET;
    end else if (mgmt_wr_i && hit_page) begin
      page_reg <= mgmt_wdata_i; // RULE10 RULE11
    end else if (soft_reset_i) begin
      page_reg <= PAGE_MAIN;
    end
  end

  assign reg_page_o = page_reg;

  //////////////////////////////////////////////////////////////////////////
  // wake and interface control register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_reg <= CTL_RESET; // RULE4 RULE5 RULE6 RULE13
    end else if (mgmt_wr_i && hit_ctl) begin
      ctl_reg <= mgmt_wdata_i & CTL_WMASK; // RULE3
    end
  end

  assign secure_on_enable_o   = ctl_reg[CTL_SECURE_BIT]; // RULE3
  assign password_four_byte_o = ctl_reg[CTL_PWLEN_BIT]; // RULE3
  assign addr_repeat_total_o  =
    5'(ctl_reg[CTL_REP_LSB +: CTL_REP_W]) + 5'h01; // RULE4
  assign mac_if_edge_rate_o   = ctl_reg[CTL_RATE_LSB +: CTL_RATE_W]; // RULE5
  assign reduced_mii_reference_clock_out_en_o = ctl_reg[CTL_RMII_BIT]; // RULE6

  //////////////////////////////////////////////////////////////////////////
  // sticky storage
  wlirp_store #(
    .WORDS (STORE_WORDS),
    .WIDTH (REG_W)
  ) u_store (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .acc     (store_acc),
    .rdata_o (store_rdata),
    .words_o (store_words)
  );

  assign wake_mac_addr_o = store_words[31:0]; // RULE1
  assign wake_password_o = store_words[79:32]; // RULE2

  //////////////////////////////////////////////////////////////////////////
  // event mask and status
  always_comb begin
    evt_vec                        = 16'h0000;
    evt_vec[EVT_RX_BIT]            = rx_fifo_err_i;
    evt_vec[EVT_TX_BIT]            = tx_fifo_err_i;
    evt_vec[EVT_EEE_W-1:0]         = eee_event_i; // RULE9
  end

  wlirp_event_unit #(
    .BITS (EVT_BITS)
  ) u_evt (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .soft_reset_i (soft_reset_i),
    .acc          (evt_acc),
    .event_i      (evt_vec),
    .rdata_o      (evt_rdata),
    .status_o     (evt_status),
    .mask_o       (evt_mask),
    .irq_o        (irq)
  );

  assign event_irq_o = irq;

  //////////////////////////////////////////////////////////////////////////
  // interrupt pin: push-pull when cmos drive set, else open drain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_n_reg    <= 1'b1;
      int_oe_n_reg <= 1'b1;
    end else begin
      int_n_reg    <= ~irq; // RULE12
      int_oe_n_reg <= ~(irq || ctl_reg[CTL_CMOS_BIT]);
    end
  end

  assign management_interrupt_pin_n_o    = int_n_reg;
  assign management_interrupt_pin_oe_n_o  = int_oe_n_reg;

  //////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rsel_next = RSEL_ZERO;
    if (hit_page || hit_ctl) begin
      rsel_next = RSEL_LOCAL;
    end else if (hit_store) begin
      rsel_next = RSEL_STORE;
    end else if (hit_evt) begin
      rsel_next = RSEL_EVT;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsel_reg        <= RSEL_ZERO;
      local_rdata_reg <= 16'h0000;
    end else if (mgmt_rd_i) begin
      rsel_reg        <= rsel_next;
      local_rdata_reg <= hit_page ? page_reg : ctl_reg;
    end
  end

  always_comb begin
    case (rsel_reg)
      RSEL_LOCAL: mgmt_rdata_o = local_rdata_reg;
      RSEL_STORE: mgmt_rdata_o = store_rdata;
      RSEL_EVT:   mgmt_rdata_o = evt_rdata;
      default:    mgmt_rdata_o = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_mac_wr;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && ext_page && mgmt_addr_i == IDX_MAC_UPPER
    |=> wake_mac_addr_o[31:16] == $past(mgmt_wdata_i);
  endproperty
  a_mac_wr: assert property (p_mac_wr) // RULE1
    else $error("upper wake address write lost");

  property p_pw_wr;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && ext_page && mgmt_addr_i == IDX_PW_LOW
    |=> wake_password_o[15:0] == $past(mgmt_wdata_i);
  endproperty
  a_pw_wr: assert property (p_pw_wr) // RULE2
    else $error("low password write lost");

  property p_secure;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && hit_ctl
    |=> secure_on_enable_o == $past(mgmt_wdata_i[CTL_SECURE_BIT])
        && password_four_byte_o == $past(mgmt_wdata_i[CTL_PWLEN_BIT]);
  endproperty
  a_secure: assert property (p_secure) // RULE3
    else $error("password control bits wrong");

  property p_repeat;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && hit_ctl
    |=> addr_repeat_total_o == 5'($past(mgmt_wdata_i[11:8])) + 5'h01;
  endproperty
  a_repeat: assert property (p_repeat) // RULE4
    else $error("repeat count not field plus one");

  property p_rate;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && hit_ctl |=> mac_if_edge_rate_o == $past(mgmt_wdata_i[7:5]);
  endproperty
  a_rate: assert property (p_rate) // RULE5
    else $error("edge rate field wrong");

  property p_ctl_reset;
    @(posedge clk_i) disable iff (reset_i)
    $fell(reset_i) |-> addr_repeat_total_o == 5'h10
      && mac_if_edge_rate_o == 3'h7 && reduced_mii_reference_clock_out_en_o
      && !secure_on_enable_o;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) // RULE6
    else $error("control defaults wrong after reset");

  property p_sticky;
    @(posedge clk_i) disable iff (reset_i)
    soft_reset_i && !mgmt_wr_i
    |=> $stable(ctl_reg) && $stable(wake_password_o) && $stable(evt_mask);
  endproperty
  a_sticky: assert property (p_sticky) // RULE13
    else $error("sticky bits disturbed by soft reset");

  property p_pin;
    @(posedge clk_i) disable iff (reset_i)
    irq |=> !management_interrupt_pin_n_o
            && !management_interrupt_pin_oe_n_o;
  endproperty
  a_pin: assert property (p_pin) // RULE12
    else $error("interrupt pin not driven low");

  property p_offpage;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && !ext_page && mgmt_addr_i == IDX_CTL |=> $stable(ctl_reg);
  endproperty
  a_offpage: assert property (p_offpage) // RULE10
    else $error("control written from another page");

  property p_page_rd;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_rd_i && hit_page |=> mgmt_rdata_o == $past(page_reg);
  endproperty
  a_page_rd: assert property (p_page_rd) // RULE11
    else $error("page register read back wrong");

  c_ext_enter: cover property (@(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && hit_page && mgmt_wdata_i == PAGE_EXT2 ##1 ext_page);
  c_gp_enter: cover property (@(posedge clk_i) disable iff (reset_i)
    mgmt_wr_i && hit_page && mgmt_wdata_i == PAGE_GP);
  c_irq: cover property (@(posedge clk_i) disable iff (reset_i)
    rx_fifo_err_i && evt_mask[EVT_RX_BIT] ##1 irq);

endmodule : wlirp_page

/* File: design/wlirp_pkg.sv */
/*
  wlirp_pkg: offsets, field positions, reset values and select codes of the
  wake-on-lan / extended event register page.
  assumes: 5-bit register index, 16-bit register data, page select in 31.
*/
package wlirp_pkg;

  localparam int          REG_W          = 16;
  localparam int          IDX_W          = 5;

  // register indices
  localparam logic [4:0]  IDX_MAC_MID    = 5'h16;
  localparam logic [4:0]  IDX_MAC_UPPER  = 5'h17;
  localparam logic [4:0]  IDX_PW_LOW     = 5'h18;
  localparam logic [4:0]  IDX_PW_MID     = 5'h19;
  localparam logic [4:0]  IDX_PW_UPPER   = 5'h1a;
  localparam logic [4:0]  IDX_CTL        = 5'h1b;
  localparam logic [4:0]  IDX_EVT_MASK   = 5'h1c;
  localparam logic [4:0]  IDX_EVT_STATUS = 5'h1d;
  localparam logic [4:0]  IDX_PAGE       = 5'h1f;

  // page select codes
  localparam logic [15:0] PAGE_MAIN      = 16'h0000;
  localparam logic [15:0] PAGE_EXT2      = 16'h0002;
  localparam logic [15:0] PAGE_GP        = 16'h0010;
  localparam logic [15:0] PAGE_RESET     = 16'h0000;

  // control register fields
  localparam int          CTL_SECURE_BIT = 15;
  localparam int          CTL_PWLEN_BIT  = 14;
  localparam int          CTL_REP_LSB    = 8;
  localparam int          CTL_REP_W      = 4;
  localparam int          CTL_RATE_LSB   = 5;
  localparam int          CTL_RATE_W     = 3;
  localparam int          CTL_RMII_BIT   = 4;
  localparam int          CTL_CMOS_BIT   = 0;
  localparam logic [15:0] CTL_RESET      = 16'h0ff0;
  localparam logic [15:0] CTL_WMASK      = 16'hcff1;

  // event register fields
  localparam int          EVT_RX_BIT     = 13;
  localparam int          EVT_TX_BIT     = 12;
  localparam int          EVT_EEE_W      = 4;
  localparam logic [15:0] EVT_BITS       = 16'h300f;
  localparam logic [15:0] EVT_RESET      = 16'h0000;
  localparam logic [15:0] STORE_RESET    = 16'h0000;

  // storage word count (mac mid/upper, three password words)
  localparam int          STORE_WORDS    = 5;

  typedef enum logic [1:0] {
    RSEL_ZERO,
    RSEL_LOCAL,
    RSEL_STORE,
    RSEL_EVT
  } wlirp_rsel_t;

endpackage : wlirp_pkg

/* File: design/wlirp_store.sv */
/*
  wlirp_store: sticky word storage for wake address and password words.
  assumes: only the hardware reset clears it; read data registered.
*/
`timescale 1ns/1ps
module wlirp_store
  import wlirp_pkg::*;
#(
  parameter int WORDS = STORE_WORDS,
  parameter int WIDTH = REG_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  wlirp_acc_if.unit                   acc,
  output logic [WIDTH-1:0]            rdata_o,
  output logic [WORDS*WIDTH-1:0]      words_o
);

  if (WORDS < 1 || WORDS > 8 || WIDTH != REG_W) begin : g_chk
    $error("wlirp_store: unsupported size");
  end

  logic [WIDTH-1:0] mem_reg [WORDS];

  //////////////////////////////////////////////////////////////////////////
  for (genvar w = 0; w < WORDS; w++) begin : g_word
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        mem_reg[w] <= STORE_RESET;
      end else if (acc.sel && acc.wr && acc.idx == 3'(w)) begin
        mem_reg[w] <= acc.wdata; // RULE1 RULE2 RULE13
      end
    end
    assign words_o[w*WIDTH +: WIDTH] = mem_reg[w];
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= STORE_RESET;
    end else if (acc.sel && acc.rd) begin
      rdata_o <= (int'(acc.idx) < WORDS) ? mem_reg[acc.idx] : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  property p_store_hold;
    @(posedge clk_i) disable iff (reset_i)
    !(acc.sel && acc.wr) |=> $stable(words_o);
  endproperty
  a_store_hold: assert property (p_store_hold) // RULE1
    else $error("storage changed without a write");

endmodule : wlirp_store

/* File: tb/wlirp_mgmt_model.sv */
/*
  wlirp_mgmt_model: station management controller model issuing indexed
  register write and read strobes to the register page.
  assumes: one clock; drives on the falling edge, one strobe cycle each.
*/
`timescale 1ns/1ps
module wlirp_mgmt_model (
  input  wire logic        clk_i,
  output logic [4:0]       addr_o,
  output logic [15:0]      wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o  = 5'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one strobe cycle, then scrambled idle bus
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = w;
    rd_o    = ~w;
    @(negedge clk_i);
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : xfer

  // page select through index 31
  task automatic set_page(input logic [15:0] code);
    xfer(1'b1, 5'h1f, code);
  endtask : set_page
endmodule : wlirp_mgmt_model

/* File: tb/wlirp_page_tb.sv */
/*
  wlirp_page_tb: self-checking bench for the wake / event register page.
  assumes: design package wlirp_pkg; page 0x0002 selects this page.
*/
`timescale 1ns/1ps
module wlirp_page_tb;
  import wlirp_pkg::*;
  logic        clk_i, reset_i, soft_reset_i, m_wr, m_rd, rd_d;
  logic [4:0]  m_addr, rep;
  logic [15:0] m_wdata, rdata, page, ev, r;
  logic [31:0] mac;
  logic [47:0] pw;
  logic [2:0]  rate;
  logic        sec, four, rmii, irq, pin_n, pin_oe_n;
  logic [15:0] exp_q[$];
  logic [15:0] w[5];
  int          bad_count, num_checks;
  int          bits[6] = '{13, 12, 3, 2, 1, 0};

  wlirp_mgmt_model u_mgmt (.clk_i(clk_i), .addr_o(m_addr),
    .wdata_o(m_wdata), .wr_o(m_wr), .rd_o(m_rd));

  wlirp_page u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .soft_reset_i(soft_reset_i), .mgmt_addr_i(m_addr),
    .mgmt_wdata_i(m_wdata), .mgmt_wr_i(m_wr), .mgmt_rd_i(m_rd),
    .mgmt_rdata_o(rdata), .reg_page_o(page), .rx_fifo_err_i(ev[13]),
    .tx_fifo_err_i(ev[12]), .eee_event_i(ev[3:0]),
    .wake_mac_addr_o(mac), .wake_password_o(pw),
    .secure_on_enable_o(sec), .password_four_byte_o(four),
    .addr_repeat_total_o(rep), .mac_if_edge_rate_o(rate),
    .reduced_mii_reference_clock_out_en_o(rmii), .event_irq_o(irq),
    .management_interrupt_pin_n_o(pin_n),
    .management_interrupt_pin_oe_n_o(pin_oe_n));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    u_mgmt.xfer(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_mgmt.xfer(1'b0, a, 16'h0000);
  endtask : rd_exp

  task automatic pulse_ev(input logic [15:0] v);
    @(negedge clk_i);
    ev = v;
    @(negedge clk_i);
    ev = 16'h0000;
  endtask : pulse_ev

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // read data watcher: one cycle after each read strobe
  always_ff @(posedge clk_i) rd_d <= m_rd;
  always @(negedge clk_i) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[FAIL] t=%0t seen=%h exp=none", $time, rdata);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h40f5));
    reset_i = 1'b1;
    soft_reset_i = 1'b0;
    ev = 16'h0000;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    check({rep, rate, rmii}, {5'd16, 3'h7, 1'b1});
    check({sec, four, irq, pin_n, pin_oe_n}, 5'b00011);
    u_mgmt.set_page(PAGE_EXT2);
    rd_exp(IDX_PAGE, PAGE_EXT2);
    for (int i = 0; i < 5; i++) rd_exp(5'(IDX_MAC_MID + i), 16'h0000);
    rd_exp(IDX_CTL, CTL_RESET);
    rd_exp(IDX_EVT_MASK, 16'h0000);
    rd_exp(IDX_EVT_STATUS, 16'h0000);
    // storage words with random data
    for (int i = 0; i < 5; i++) begin
      w[i] = 16'($urandom);
      wr_reg(5'(IDX_MAC_MID + i), w[i]);
    end
    for (int i = 0; i < 5; i++) rd_exp(5'(IDX_MAC_MID + i), w[i]);
    check(mac, {w[1], w[0]});
    check(pw, {w[4], w[3], w[2]});
    // control fields, reserved bits dropped
    wr_reg(IDX_CTL, 16'hffff);
    rd_exp(IDX_CTL, 16'hcff1);
    check({sec, four, rep, rate, rmii, pin_oe_n}, 12'he1e);
    for (int n = 0; n < 16; n++) begin
      wr_reg(IDX_CTL, {4'h0, 4'(n), 3'(n), 5'h00});
      check({rep, rate}, {5'(n + 1), 3'(n)});
    end
    check({sec, four, rmii}, 3'b000);
    // each event raises status and interrupt, read clears
    wr_reg(IDX_EVT_MASK, 16'hffff);
    rd_exp(IDX_EVT_MASK, EVT_BITS);
    foreach (bits[k]) begin
      pulse_ev(16'h0001 << bits[k]);
      check(irq, 1'b1);
      @(negedge clk_i);
      check({pin_n, pin_oe_n}, 2'b00);
      rd_exp(IDX_EVT_STATUS, 16'h0001 << bits[k]);
      check(irq, 1'b0);
      rd_exp(IDX_EVT_STATUS, 16'h0000);
    end
    // masked events: status only, no interrupt
    wr_reg(IDX_EVT_MASK, 16'h0000);
    r = (16'($urandom) & EVT_BITS) | 16'h0001;
    pulse_ev(r);
    @(negedge clk_i);
    check({irq, pin_n}, 2'b01);
    wr_reg(IDX_EVT_STATUS, 16'h0000);
    rd_exp(IDX_EVT_STATUS, r);
    // soft reset keeps sticky words, clears status and page
    wr_reg(IDX_EVT_MASK, 16'h2001);
    wr_reg(IDX_CTL, 16'hc001);
    pulse_ev(16'h2000);
    @(negedge clk_i);
    soft_reset_i = 1'b1;
    @(negedge clk_i);
    soft_reset_i = 1'b0;
    check(page, PAGE_MAIN);
    check({sec, four, mac}, {2'b11, w[1], w[0]});
    check(pw, {w[4], w[3], w[2]});
    u_mgmt.set_page(PAGE_EXT2);
    rd_exp(IDX_EVT_STATUS, 16'h0000);
    rd_exp(IDX_EVT_MASK, 16'h2001);
    // other pages do not reach this storage
    u_mgmt.set_page(PAGE_GP);
    rd_exp(IDX_MAC_MID, 16'h0000);
    wr_reg(IDX_MAC_MID, ~w[0]);
    check(mac, {w[1], w[0]});
    u_mgmt.set_page(PAGE_MAIN);
    check(page, PAGE_MAIN);
    rd_exp(IDX_PW_LOW, 16'h0000);
    // hardware reset in mid-run clears sticky words
    @(negedge clk_i);
    reset_i = 1'b1;
    @(negedge clk_i);
    reset_i = 1'b0;
    check({mac, rep, sec}, {32'h0, 5'd16, 1'b0});
    check(pw, 48'h0);
    repeat (3) @(negedge clk_i);
    finish_test();
  end
endmodule : wlirp_page_tb
